// [tshp_port.sv]
// Subsystem-side handshake port: word transfers over an 8-bit highway, command
// reporting, mode-code event pulses and status bits, programmed over APB.
// Assumes all pin inputs are synchronous to clk; the highway wire is resolved outside.
`timescale 1ns/100ps
`default_nettype none

module tshp_port
  import tshp_pkg::*;
#(
  parameter int ACK_W = 8
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire tshp_pkg::tshp_apb_req_t apbReq,
  output tshp_pkg::tshp_apb_rsp_t      apbRsp,
  input  wire logic             transferAckN,
  input  wire logic             messageErrorRequest,
  input  wire logic             subsystemFaultN,
  input  wire logic             subsystemBusyN,
  input  wire logic             asyncTransferRequestN,
  input  wire logic [7:0]       internalByteBusIn,
  output logic [7:0]            internalByteBusOut,
  output logic                  internalByteBusOe,
  output logic                  transferRequestN,
  output logic                  byteStrobeN,
  output logic                  byteSelect,
  output logic                  directionSupply,
  output logic                  commandActiveN,
  output tshp_pkg::tshp_cmd_t   commandInfo,
  output logic                  syncModeN,
  output logic                  vectorOrModeDataEnableN,
  output logic                  goodBlockPulseN,
  output logic                  newCommandPulseN,
  output logic                  resetPulseN,
  output logic                  handshakeTimeoutN
);

  import tshp_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    tshp_xfer_e    xfer;
    logic [7:0]    tickAcc;
    logic          tick;
    logic [ACK_W-1:0] waitCnt;
    logic [ACK_W-1:0] ackLimit;
    logic          pendStart;
    logic          bcMode;
    logic          supply;
    logic          cmdActiveN;
    logic          syncModeN;
    logic          vecEnN;
    tshp_cmd_t     cmd;
    logic [15:0]   txWord;
    logic [15:0]   rxWord;
    logic          rxValid;
    logic          msgError;
    logic          subsysFlag;
    logic          timeoutFlag;
    logic          msgReqPrev;
    logic          reqN;
    logic          strobeN;
    logic          byteSel;
    logic [7:0]    busOut;
    logic          busOe;
    logic          fireNewCmd;
    logic          fireGood;
    logic          fireReset;
    logic          fireFail;
    tshp_apb_rsp_t rsp;
  } tshp_state_t;

  tshp_state_t state_q;
  tshp_state_t state_d;

  logic        setupPhase;
  logic        wrAccess;
  logic        mapped;
  logic [31:0] readWord;
  logic [31:0] wd;

  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign wrAccess   = apbReq.psel && apbReq.penable && state_q.rsp.pready && apbReq.pwrite
                      && !state_q.rsp.pslverr;
  assign wd         = apbReq.pwdata;

  // ==========================================================================
  // Register read mux
  always_comb
  begin
    readWord = '0;
    mapped   = 1'b1;
    unique case (apbReq.paddr)
      REG_CTRL:
      begin
        readWord[CTRL_BC_MODE] = state_q.bcMode;
        readWord[CTRL_SYNC]    = !state_q.syncModeN;
        readWord[CTRL_CMD_ACT] = !state_q.cmdActiveN;
        readWord[CTRL_VEC_EN]  = !state_q.vecEnN;
        readWord[CTRL_SUPPLY]  = state_q.supply;
      end
      REG_CMD:
      begin
        readWord[CMD_SA_LSB +: 5]  = state_q.cmd.subaddressLabel;
        readWord[CMD_WC_LSB +: 5]  = state_q.cmd.requestedWordCount;
        readWord[CMD_IDX_LSB +: 5] = state_q.cmd.currentWordIndex;
      end
      REG_TXDATA:  readWord[15:0] = state_q.txWord;
      REG_RXDATA:  readWord[15:0] = state_q.rxWord;
      REG_STATUS:
      begin
        readWord[ST_XFER_BUSY] = (state_q.xfer != XF_IDLE) || state_q.pendStart;
        readWord[ST_MSG_ERR]   = state_q.msgError;
        readWord[ST_SUBSYS]    = state_q.subsysFlag;
        readWord[ST_TIMEOUT]   = state_q.timeoutFlag;
        readWord[ST_BUSY_IN]   = !subsystemBusyN;
        readWord[ST_SERV_REQ]  = !asyncTransferRequestN;
        readWord[ST_RX_VALID]  = state_q.rxValid;
      end
      REG_TIMEOUT: readWord[ACK_W-1:0] = state_q.ackLimit;
      default:     mapped = 1'b0;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    state_d            = state_q;
    state_d.fireNewCmd = 1'b0;
    state_d.fireGood   = 1'b0;
    state_d.fireReset  = 1'b0;
    state_d.fireFail   = 1'b0;

    // Fractional divider: 6 MHz tick on average from the 100 MHz clock
    if (state_q.tickAcc + 8'(MCLK_MHZ) >= 8'(CLK_MHZ))
    begin
      state_d.tickAcc = state_q.tickAcc + 8'(MCLK_MHZ) - 8'(CLK_MHZ);
      state_d.tick    = 1'b1;
    end
    else
    begin
      state_d.tickAcc = state_q.tickAcc + 8'(MCLK_MHZ);
      state_d.tick    = 1'b0;
    end

    // APB answer one cycle after setup
    state_d.rsp.pready  = setupPhase;
    state_d.rsp.pslverr = setupPhase && !mapped;
    state_d.rsp.prdata  = setupPhase && !apbReq.pwrite ? readWord : '0;

    // Status events; hardware set wins over a software clear in the same cycle
    state_d.msgReqPrev = messageErrorRequest;
    if (wrAccess && apbReq.paddr == REG_STATUS)
    begin
      if (wd[ST_MSG_ERR])
        state_d.msgError = 1'b0;
      if (wd[ST_SUBSYS])
        state_d.subsysFlag = 1'b0;
      if (wd[ST_TIMEOUT])
        state_d.timeoutFlag = 1'b0;
      if (wd[ST_RX_VALID])
        state_d.rxValid = 1'b0;
    end
    if (messageErrorRequest && !state_q.msgReqPrev)
      state_d.msgError = 1'b1;
    if (!subsystemFaultN)
      state_d.subsysFlag = 1'b1;

    // Register writes
    if (wrAccess)
    begin
      unique case (apbReq.paddr)
        REG_CTRL:
        begin
          state_d.bcMode     = wd[CTRL_BC_MODE];
          // Active-low pins are held inverted so each output comes straight from a flop
          state_d.syncModeN  = !wd[CTRL_SYNC];
          state_d.cmdActiveN = !wd[CTRL_CMD_ACT];
          state_d.vecEnN     = !wd[CTRL_VEC_EN];
          state_d.supply     = wd[CTRL_SUPPLY];
          state_d.fireNewCmd = wd[CTRL_NEW_CMD];
          state_d.fireGood   = wd[CTRL_GOOD_BLK];
          state_d.fireReset  = wd[CTRL_RESET_CMD];
          if (wd[CTRL_START])
            state_d.pendStart = 1'b1;
        end
        REG_CMD:
        begin
          state_d.cmd.subaddressLabel    = wd[CMD_SA_LSB +: 5];
          state_d.cmd.requestedWordCount = wd[CMD_WC_LSB +: 5];
          state_d.cmd.currentWordIndex   = wd[CMD_IDX_LSB +: 5];
        end
        REG_TXDATA:  state_d.txWord   = wd[15:0];
        REG_TIMEOUT: state_d.ackLimit = wd[ACK_W-1:0];
        default:
        begin
        end
      endcase
    end

    // Word transfer sequencer, stepped at the master clock rate
    if (state_q.tick)
    begin
      unique case (state_q.xfer)
        XF_IDLE:
        begin
          // A busy subsystem holds the start off until it can take part
          if (state_q.pendStart && subsystemBusyN)
          begin
            state_d.pendStart = 1'b0;
            state_d.reqN      = 1'b0;
            state_d.waitCnt   = '0;
            state_d.xfer      = XF_REQ;
          end
        end
        XF_REQ:
        begin
          if (!transferAckN)
          begin
            state_d.xfer    = XF_HI_SET;
            state_d.byteSel = 1'b1;
            state_d.busOut  = state_q.txWord[15:8];
            // Device drives only when the subsystem accepts and no enable grants it the bus
            state_d.busOe   = !state_q.supply && state_q.vecEnN;
          end
          else if (state_q.waitCnt + 1'b1 >= state_q.ackLimit)
          begin
            state_d.reqN        = 1'b1;
            state_d.timeoutFlag = 1'b1;
            state_d.fireFail    = 1'b1;
            state_d.xfer        = XF_IDLE;
          end
          else
          begin
            state_d.waitCnt = state_q.waitCnt + 1'b1;
          end
        end
        XF_HI_SET:
        begin
          state_d.strobeN = 1'b0;
          state_d.xfer    = XF_HI_STB;
        end
        XF_HI_STB:
        begin
          state_d.strobeN = 1'b1;
          if (state_q.supply)
            state_d.rxWord[15:8] = internalByteBusIn;
          state_d.byteSel = 1'b0;
          state_d.busOut  = state_q.txWord[7:0];
          state_d.xfer    = XF_LO_SET;
        end
        XF_LO_SET:
        begin
          state_d.strobeN = 1'b0;
          state_d.xfer    = XF_LO_STB;
        end
        XF_LO_STB:
        begin
          state_d.strobeN = 1'b1;
          if (state_q.supply)
          begin
            state_d.rxWord[7:0] = internalByteBusIn;
            state_d.rxValid     = 1'b1;
          end
          state_d.xfer = XF_END;
        end
        XF_END:
        begin
          state_d.busOe   = 1'b0;
          state_d.reqN    = 1'b1;
          state_d.byteSel = 1'b0;
          state_d.xfer    = XF_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q             <= '0;
      state_q.xfer        <= XF_IDLE;
      state_q.ackLimit    <= ACK_W'(ACK_LIMIT_RESET);
      state_q.reqN        <= 1'b1;
      state_q.strobeN     <= 1'b1;
      state_q.cmdActiveN  <= 1'b1;
      state_q.syncModeN   <= 1'b1;
      state_q.vecEnN      <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Event pulses
  tshp_pulse #(.CYCLES(PULSE_LONG_CYC)) goodPulse (
    .clk    (clk),
    .rstn   (rstn),
    .fire   (state_q.fireGood),
    .pulseN (goodBlockPulseN)
  );

  tshp_pulse #(.CYCLES(PULSE_LONG_CYC)) resetPulse (
    .clk    (clk),
    .rstn   (rstn),
    .fire   (state_q.fireReset),
    .pulseN (resetPulseN)
  );

  // Short pulses last one master clock period
  tshp_pulse #(.CYCLES(MCLK_CYC)) newCmdPulse (
    .clk    (clk),
    .rstn   (rstn),
    .fire   (state_q.fireNewCmd),
    .pulseN (newCommandPulseN)
  );

  tshp_pulse #(.CYCLES(MCLK_CYC)) failPulse (
    .clk    (clk),
    .rstn   (rstn),
    .fire   (state_q.fireFail),
    .pulseN (handshakeTimeoutN)
  );

  // ==========================================================================
  // Outputs
  assign apbRsp                  = state_q.rsp;
  assign internalByteBusOut      = state_q.busOut;
  assign internalByteBusOe       = state_q.busOe;
  assign transferRequestN        = state_q.reqN;
  assign byteStrobeN             = state_q.strobeN;
  assign byteSelect              = state_q.byteSel;
  assign directionSupply         = state_q.supply;
  assign commandActiveN          = state_q.cmdActiveN;
  assign commandInfo             = state_q.cmd;
  assign syncModeN               = state_q.syncModeN;
  assign vectorOrModeDataEnableN = state_q.vecEnN;

endmodule // tshp_port

`default_nettype wire

// [tshp_pkg.sv]
// Constants, field layouts and carrier types for the terminal subsystem handshake port.
// Assumes a single 100 MHz clock with a synchronous active-low reset and APB register access.

package tshp_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ        = 100;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int MCLK_MHZ       = 6;
  localparam int PULSE_LONG_NS  = 500;
  localparam int PULSE_LONG_CYC = (PULSE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MCLK_CYC       = (CLK_MHZ + MCLK_MHZ - 1) / MCLK_MHZ;
  localparam logic [7:0] ACK_LIMIT_RESET = 8'h10;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_CMD     = 8'h04;
  localparam logic [7:0] REG_TXDATA  = 8'h08;
  localparam logic [7:0] REG_RXDATA  = 8'h0c;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_TIMEOUT = 8'h14;

  // CTRL fields
  localparam int CTRL_BC_MODE   = 0;
  localparam int CTRL_START     = 1;
  localparam int CTRL_NEW_CMD   = 2;
  localparam int CTRL_GOOD_BLK  = 3;
  localparam int CTRL_RESET_CMD = 4;
  localparam int CTRL_SYNC      = 5;
  localparam int CTRL_CMD_ACT   = 6;
  localparam int CTRL_VEC_EN    = 7;
  localparam int CTRL_SUPPLY    = 8;

  // CMD fields
  localparam int CMD_SA_LSB  = 0;
  localparam int CMD_WC_LSB  = 8;
  localparam int CMD_IDX_LSB = 16;

  // STATUS fields
  localparam int ST_XFER_BUSY = 0;
  localparam int ST_MSG_ERR   = 1;
  localparam int ST_SUBSYS    = 2;
  localparam int ST_TIMEOUT   = 3;
  localparam int ST_BUSY_IN   = 4;
  localparam int ST_SERV_REQ  = 5;
  localparam int ST_RX_VALID  = 6;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [4:0] subaddressLabel;
    logic [4:0] requestedWordCount;
    logic [4:0] currentWordIndex;
  } tshp_cmd_t;

  typedef struct packed {
    logic [7:0] paddr;
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [31:0] pwdata;
  } tshp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tshp_apb_rsp_t;

  typedef enum logic [2:0] {
    XF_IDLE,
    XF_REQ,
    XF_HI_SET,
    XF_HI_STB,
    XF_LO_SET,
    XF_LO_STB,
    XF_END
  } tshp_xfer_e;

endpackage

// [tshp_pulse.sv]
// Fixed-length active-low pulse generator.
// Assumes fire is a one-cycle request on clk; a fire during a pulse restarts it.
`timescale 1ns/100ps
`default_nettype none

module tshp_pulse #(
  parameter int CYCLES = 50
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic fire,
  output logic      pulseN
);

  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          pulseN;
  } tshp_pulse_state_t;

  tshp_pulse_state_t state_q;
  tshp_pulse_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    if (fire)
    begin
      state_d.count  = CW'(CYCLES - 1);
      state_d.pulseN = 1'b0;
    end
    else if (state_q.count != '0)
    begin
      state_d.count = state_q.count - 1'b1;
    end
    else
    begin
      state_d.pulseN = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state_q.count  <= '0;
      state_q.pulseN <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign pulseN = state_q.pulseN;

endmodule // tshp_pulse

`default_nettype wire

// [tshp_port_assertions.sv]
// Checker for the handshake port: strobe order, pulse widths, APB answer timing.
// Assumes a bind onto every tshp_port; sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none

module tshp_chk
  import tshp_pkg::*;
(
  input wire logic                    clk,
  input wire logic                    rstn,
  input wire tshp_pkg::tshp_apb_req_t apbReq,
  input wire tshp_pkg::tshp_apb_rsp_t apbRsp,
  input wire logic                    transferRequestN,
  input wire logic                    byteStrobeN,
  input wire logic                    byteSelect,
  input wire logic                    directionSupply,
  input wire logic                    internalByteBusOe,
  input wire logic                    vectorOrModeDataEnableN,
  input wire logic                    goodBlockPulseN,
  input wire logic                    resetPulseN,
  input wire logic                    newCommandPulseN,
  input wire logic                    handshakeTimeoutN
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // ==========================================================================
  // Helper counters: low time of each pulse, strobes within one request
  logic [3:0] pulseN;
  logic [5:0] lowCnt_q [4];
  logic [1:0] stbCnt_q;
  assign pulseN = {goodBlockPulseN, resetPulseN, newCommandPulseN, handshakeTimeoutN};
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 4; i++)
      lowCnt_q[i] <= (!rstn || pulseN[i]) ? 6'h00 : lowCnt_q[i] + 6'h01;
    if (!rstn || transferRequestN)
      stbCnt_q <= 2'h0;
    else if ($fell(byteStrobeN))
      stbCnt_q <= stbCnt_q + 2'h1;
  end

  // ==========================================================================
  // Assertions
  a_strobe_in_req: assert property (!byteStrobeN |-> !transferRequestN)
    else $error("byte strobe outside a request");
  a_hi_byte_first: assert property (
    $fell(byteStrobeN) |-> byteSelect == (stbCnt_q == 2'h0))
    else $error("byte select wrong at strobe");
  a_two_strobes: assert property ($rose(transferRequestN) |-> stbCnt_q inside {2'h0, 2'h2})
    else $error("word ended without two strobes");
  a_timeout_flag: assert property (
    $rose(transferRequestN) && stbCnt_q == 2'h0 |-> ##[0:20] !handshakeTimeoutN)
    else $error("aborted transfer without failure pulse");
  a_good_blk_len: assert property (
    $rose(goodBlockPulseN) |-> lowCnt_q[3] == PULSE_LONG_CYC)
    else $error("good-block pulse width wrong");
  a_reset_len: assert property ($rose(resetPulseN) |-> lowCnt_q[2] == PULSE_LONG_CYC)
    else $error("reset pulse width wrong");
  a_new_cmd_len: assert property ($rose(newCommandPulseN) |-> lowCnt_q[1] == MCLK_CYC)
    else $error("new-command pulse width wrong");
  a_hsto_len: assert property ($rose(handshakeTimeoutN) |-> lowCnt_q[0] == MCLK_CYC)
    else $error("failure pulse width wrong");
  a_apb_ready: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
    else $error("no ready after setup");
  a_drive_outbound: assert property (
    internalByteBusOe |-> !transferRequestN && !directionSupply && vectorOrModeDataEnableN)
    else $error("device drives highway out of turn");

  c_word_done: cover property ($rose(transferRequestN) && stbCnt_q == 2'h2);
  c_word_abort: cover property ($rose(transferRequestN) && stbCnt_q == 2'h0);
  c_good_blk: cover property ($rose(goodBlockPulseN));
endmodule // tshp_chk

bind tshp_port tshp_chk tshp_chk_inst (.clk, .rstn, .apbReq, .apbRsp, .transferRequestN,
  .byteStrobeN, .byteSelect, .directionSupply, .internalByteBusOe, .vectorOrModeDataEnableN,
  .goodBlockPulseN, .resetPulseN, .newCommandPulseN, .handshakeTimeoutN);

`default_nettype wire

// [tshp_subsys_model.sv]
// Subsystem model: acknowledges word requests, supplies or captures bytes.
// Assumes the bench sets ackDelay, noAck and txWord; resolves the highway.
`timescale 1ns/100ps
`default_nettype none

module tshp_subsys_model (
  input  wire logic        clk,
  input  wire logic        transferRequestN,
  input  wire logic        byteStrobeN,
  input  wire logic        byteSelect,
  input  wire logic        directionSupply,
  input  wire logic        vectorOrModeDataEnableN,
  input  wire logic [7:0]  busOut,
  input  wire logic        busOe,
  input  wire logic [7:0]  ackDelay,
  input  wire logic        noAck,
  input  wire logic [15:0] txWord,
  output logic             transferAckN,
  output logic [7:0]       busIn,
  output logic [15:0]      rxWord,
  output logic [2:0]       strobes
);
  logic [7:0] waitCnt;
  logic [7:0] lastBus;
  logic       stbQ;
  logic       drive;
  // Drive only inbound data after acknowledging, or while the enable is low
  assign drive = (directionSupply && !transferRequestN && !transferAckN)
              || !vectorOrModeDataEnableN;
  // A floating highway toggles each cycle so stale bytes cannot pass
  assign busIn = busOe ? busOut : drive ? (byteSelect ? txWord[15:8] : txWord[7:0]) : ~lastBus;
  initial
  begin
    transferAckN = 1'b1;
    waitCnt = 8'h00;
    lastBus = 8'h00;
    stbQ = 1'b1;
  end
  always @(posedge clk)
  begin
    lastBus <= busIn;
    stbQ <= byteStrobeN;
    waitCnt <= transferRequestN ? 8'h00 : waitCnt + 8'h01;
    if (transferRequestN)
      transferAckN <= 1'b1;
    else if (!noAck && transferAckN && waitCnt >= ackDelay)
    begin
      transferAckN <= 1'b0;
      strobes <= 3'h0;
    end
    // Bytes are taken in the first cycle of a low strobe: select and data are
    // settled then, while on the rising edge the device already moves to the next byte
    if (!transferRequestN && !byteStrobeN && stbQ)
    begin
      strobes <= strobes + 3'h1;
      if (byteSelect)
        rxWord[15:8] <= busIn;
      else
        rxWord[7:0] <= busIn;
    end
  end
endmodule // tshp_subsys_model

`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the handshake port: APB master, subsystem model.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import tshp_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, err, noAck = 1'b0;
  logic messageErrorRequest = 1'b0, subsystemFaultN = 1'b1;
  logic subsystemBusyN = 1'b1, asyncTransferRequestN = 1'b1;
  logic transferAckN, internalByteBusOe, transferRequestN, byteStrobeN, byteSelect;
  logic directionSupply, commandActiveN, syncModeN, vectorOrModeDataEnableN;
  logic goodBlockPulseN, newCommandPulseN, resetPulseN, handshakeTimeoutN;
  logic [7:0] internalByteBusIn, internalByteBusOut, ackDelay = 8'h03;
  logic [15:0] txWord = 16'h0000, rxWord;
  logic [2:0] strobes;
  logic [31:0] rd, w;
  tshp_apb_req_t apbReq = '0;
  tshp_apb_rsp_t apbRsp;
  tshp_cmd_t commandInfo, c;
  int errors = 0, num_checks = 0, seed = 27701;

  always #5 clk = ~clk;

  tshp_port tshp_port_inst (.clk, .rstn, .apbReq, .apbRsp, .transferAckN, .messageErrorRequest,
    .subsystemFaultN, .subsystemBusyN, .asyncTransferRequestN, .internalByteBusIn,
    .internalByteBusOut, .internalByteBusOe, .transferRequestN, .byteStrobeN, .byteSelect,
    .directionSupply, .commandActiveN, .commandInfo, .syncModeN, .vectorOrModeDataEnableN,
    .goodBlockPulseN, .newCommandPulseN, .resetPulseN, .handshakeTimeoutN);
  tshp_subsys_model tshp_subsys_model_inst (.clk, .transferRequestN, .byteStrobeN, .byteSelect,
    .directionSupply, .vectorOrModeDataEnableN, .busOut(internalByteBusOut),
    .busOe(internalByteBusOe), .ackDelay, .noAck, .txWord, .transferAckN,
    .busIn(internalByteBusIn), .rxWord, .strobes);

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    apbReq <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do @(posedge clk); while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    while (transferRequestN !== 1'b0 && n++ < 60) @(posedge clk);
    chk(transferRequestN, 1'b0);
    n = 0;
    while (transferRequestN !== 1'b1 && n++ < 600) @(posedge clk);
    chk(transferRequestN, 1'b1);
  endtask

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, REG_TIMEOUT, 32'h0);
    chk(rd, {24'h0, ACK_LIMIT_RESET});
    chk({transferRequestN, byteStrobeN, commandActiveN}, 3'h7);
    chk({goodBlockPulseN, resetPulseN}, 2'h3);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
    begin
      w = $random(seed);
      c = w[14:0];
      apb(1'b1, REG_CMD, {11'h0, c.currentWordIndex, 3'h0, c.requestedWordCount, 3'h0,
        c.subaddressLabel});
      w = ($random(seed) & 32'h1a1) | 32'h40;
      apb(1'b1, REG_CTRL, w);
      repeat (2) @(posedge clk);
      chk(commandActiveN, 1'b0);
      chk(commandInfo, c);
      chk(directionSupply, w[8]);
      chk(syncModeN, !w[5]);
      chk({vectorOrModeDataEnableN, internalByteBusOe}, {!w[7], 1'b0});
      apb(1'b0, REG_CTRL, 32'h0);
      chk(rd, w);
    end
    $display("test command done");
    apb(1'b1, REG_CTRL, 32'h1c);
    repeat (2) @(posedge clk);
    chk({goodBlockPulseN, newCommandPulseN, resetPulseN}, 3'h0);
    repeat (60) @(posedge clk);
    chk({goodBlockPulseN, newCommandPulseN, resetPulseN}, 3'h7);
    $display("test pulses done");
    messageErrorRequest <= 1'b1;
    subsystemFaultN <= 1'b0;
    asyncTransferRequestN <= 1'b0;
    subsystemBusyN <= 1'b0;
    apb(1'b1, REG_STATUS, 32'h6);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[2:1], 2'h2);
    chk(rd[5:4], 2'h3);
    messageErrorRequest <= 1'b0;
    subsystemFaultN <= 1'b1;
    apb(1'b1, REG_STATUS, 32'h6);
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[2:1], 2'h0);
    messageErrorRequest <= 1'b1;
    asyncTransferRequestN <= 1'b1;
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[2:1], 2'h1);
    $display("test status done");
    for (int i = 0; i < 4; i++)
    begin
      w = $random(seed);
      txWord <= w[31:16];
      ackDelay <= {3'h0, w[20:16]};
      apb(1'b1, REG_TXDATA, {16'h0, w[15:0]});
      apb(1'b1, REG_CTRL, {23'h0, i[0], 8'h02});
      if (i == 0)
      begin
        repeat (60) @(posedge clk);
        chk(transferRequestN, 1'b1);
        subsystemBusyN <= 1'b1;
      end
      wait_done();
      apb(1'b0, REG_RXDATA, 32'h0);
      if (i[0])
        chk(rd[15:0], txWord);
      else
        chk(rxWord, w[15:0]);
      chk(strobes, 3'h2);
    end
    $display("test words done");
    noAck <= 1'b1;
    apb(1'b1, REG_TIMEOUT, 32'h2);
    apb(1'b1, REG_CTRL, 32'h2);
    wait_done();
    apb(1'b0, REG_STATUS, 32'h0);
    chk(rd[3], 1'b1);
    chk(handshakeTimeoutN, 1'b0);
    noAck <= 1'b0;
    $display("test timeout done");
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule // tb_top

`default_nettype wire
